// [design/adc_serial_result_port.sv]
// Serial result port of the sampling converter, sharing the parallel pins.
// Assumes the core gives start and done pulses on i_clock; pins are async.
`timescale 1ns/1ps
module adc_serial_result_port
	import adc_serial_pkg::*;
(
	// Clock and reset
	input  wire logic                   i_clock,
	input  wire logic                   i_srst,
	// Converter core
	input  wire logic                   i_conv_start,
	input  wire logic                   i_conv_done,
	input  wire logic [RESULT_BITS-1:0] i_conv_result,
	output logic                        o_conv_ready,
	// Host control pins
	input  wire logic                   i_serial_parallel_select,
	input  wire logic                   i_output_coding_select,
	input  wire logic                   i_cs_n,
	input  wire logic                   i_rd_n,
	// Shared data pins
	input  wire logic [PIN_COUNT-1:0]   i_pin_in,
	output logic      [PIN_COUNT-1:0]   o_pin_out,
	output logic      [PIN_COUNT-1:0]   o_pin_oe_n
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [PIN_COUNT-1:0] pin_meta;
	logic [PIN_COUNT-1:0] pin_q;
	logic [3:0]           ctl_meta;
	logic [3:0]           ctl_q;
	logic                 sclk_prev;
	logic                 cs_n_prev;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			pin_meta  <= '0;
			pin_q     <= '0;
			ctl_meta  <= 4'hc;
			ctl_q     <= 4'hc;
			sclk_prev <= 1'b0;
			cs_n_prev <= 1'b1;
		end else begin
			pin_meta  <= i_pin_in;
			pin_q     <= pin_meta;
			ctl_meta  <= {i_rd_n, i_cs_n, i_output_coding_select, i_serial_parallel_select};
			ctl_q     <= ctl_meta;
			sclk_prev <= pin_q[PIN_SCLK];
			cs_n_prev <= ctl_q[2];
		end
	end

	serial_cfg_t cfg;
	logic        bus_en;
	logic        master;
	logic        slave;

	always_comb begin
		cfg.serial_mode     = ctl_q[0];
		cfg.straight_binary = ctl_q[1];
		cfg.slave_clock     = pin_q[PIN_CLOCK_SOURCE];
		cfg.sync_active_low = pin_q[PIN_SYNC_POL];
		cfg.clock_inverted  = pin_q[PIN_CLOCK_INV];
		cfg.rdc_or_chain    = pin_q[PIN_CHAIN];
	end

	assign bus_en = !ctl_q[2] && !ctl_q[3];
	assign master = cfg.serial_mode && !cfg.slave_clock;
	assign slave  = cfg.serial_mode && cfg.slave_clock;

	// ----------------------------------------------------------------
	// Result buffer and held word
	// ----------------------------------------------------------------
	logic                   fifo_valid;
	logic [RESULT_BITS-1:0] fifo_data;
	logic                   hold_take;
	logic [RESULT_BITS-1:0] held;
	logic                   held_valid;
	port_state_t            state;

	// Shifter stalls the drain, so a slow host backs the core up
	assign hold_take = fifo_valid && (state == ST_IDLE);

	result_fifo #(
		.WIDTH (RESULT_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clock     (i_clock),
		.i_srst      (i_srst),
		.i_in_valid  (i_conv_done),
		.i_in_data   (i_conv_result),
		.o_in_ready  (o_conv_ready),
		.o_out_valid (fifo_valid),
		.o_out_data  (fifo_data),
		.i_out_ready (hold_take)
	);

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			held       <= RESULT_RESET;
			held_valid <= 1'b0;
		end else if (hold_take) begin
			held       <= {fifo_data[RESULT_BITS-1] ^ !cfg.straight_binary,
				fifo_data[RESULT_BITS-2:0]};
			held_valid <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Internal bit clock divider
	// ----------------------------------------------------------------
	localparam int DIV_BITS = $clog2(MASTER_PHASE_CYCLES + 1);

	logic [DIV_BITS-1:0] div_cnt;
	logic                tick;
	logic [1:0]          phase;
	logic                sclk_int;
	logic                start;

	assign tick = (div_cnt == DIV_BITS'(MASTER_PHASE_CYCLES - 1));

	always_ff @(posedge i_clock) begin
		if (i_srst || start || tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	// edges sit mid-bit, data moves at the quarter between
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			phase    <= PHASE_RISE;
			sclk_int <= 1'b0;
		end else if (start) begin
			phase    <= PHASE_RISE;
			sclk_int <= 1'b0;
		end else if (tick) begin
			phase <= phase + 2'h1;
			if (phase == PHASE_RISE) begin
				sclk_int <= 1'b1;
			end else if (phase == PHASE_FALL) begin
				sclk_int <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read sequencer
	// ----------------------------------------------------------------
	logic                   start_master;
	logic                   start_slave;
	logic                   sclk_rise;
	logic                   sclk_fall;
	logic                   slave_upd;
	logic                   master_upd;
	logic                   abort;
	logic                   first_edge;
	logic [COUNT_BITS-1:0]  bit_cnt;
	logic [RESULT_BITS-1:0] shreg;
	logic                   rderr;
	logic [RESULT_BITS-1:0] load_word;

	assign sclk_rise = pin_q[PIN_SCLK] && !sclk_prev;
	assign sclk_fall = !pin_q[PIN_SCLK] && sclk_prev;
	// read mode picks the starting event
	assign start_master = master && bus_en && (state == ST_IDLE) &&
		(cfg.rdc_or_chain ? (i_conv_start && held_valid) : hold_take);
	assign start_slave  = slave && (state == ST_IDLE) && !ctl_q[2] && cs_n_prev;
	assign start        = start_master || start_slave;
	// New word goes straight to the shifter in read-after mode
	assign load_word    = hold_take ? {fifo_data[RESULT_BITS-1] ^ !cfg.straight_binary,
		fifo_data[RESULT_BITS-2:0]} : held;
	// host clock edge that moves the data
	assign slave_upd    = slave && (state == ST_SHIFT) && !ctl_q[2] &&
		(cfg.clock_inverted ? sclk_fall : sclk_rise);
	assign master_upd   = master && (state == ST_SHIFT) && tick && (phase == PHASE_SHIFT);
	// conversion done before sixteen bits left
	assign abort        = slave && (state == ST_SHIFT) && (bit_cnt != BITS_DONE) &&
		i_conv_done;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (start) begin
						state <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (abort || (slave && ctl_q[2]) || !cfg.serial_mode) begin
						state <= ST_IDLE;
					end else if (master_upd && bit_cnt == BITS_LAST) begin
						state <= ST_IDLE;
					end else if (!slave && !master) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// count saturates once the word is out
	always_ff @(posedge i_clock) begin
		if (i_srst || start) begin
			bit_cnt <= '0;
		end else if ((master_upd || slave_upd) && bit_cnt != BITS_DONE) begin
			bit_cnt <= bit_cnt + 5'h01;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst || start) begin
			first_edge <= 1'b1;
		end else if (slave_upd) begin
			first_edge <= 1'b0;
		end
	end

	// MSB first out of the shifter
	// in slave mode the chain level enters behind the result; master shifts in zeros
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			shreg <= RESULT_RESET;
		end else if (start) begin
			shreg <= load_word;
		end else if (master_upd) begin
			shreg <= {shreg[RESULT_BITS-2:0], 1'b0};
		end else if (slave_upd && !first_edge) begin
			shreg <= {shreg[RESULT_BITS-2:0], cfg.rdc_or_chain};
		end else if (abort) begin
			shreg <= RESULT_RESET;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			rderr <= 1'b0;
		end else begin
			rderr <= abort;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	pin_drive_t next_drive;
	pin_drive_t drive;

	always_comb begin
		next_drive.level = '0;
		next_drive.oe_n  = PINS_OFF;
		if (bus_en) begin
			if (!cfg.serial_mode) begin
				next_drive.level = held;
				next_drive.oe_n  = PINS_ALL_ON;
			end else begin
				next_drive.level[PIN_SDATA] = shreg[RESULT_BITS-1];
				next_drive.oe_n[PIN_SDATA]  = 1'b0;
				next_drive.level[PIN_SYNC]  = (master && state == ST_SHIFT) ^
					cfg.sync_active_low;
				next_drive.oe_n[PIN_SYNC]   = 1'b0;
				next_drive.level[PIN_SCLK]  = sclk_int ^ cfg.clock_inverted;
				next_drive.oe_n[PIN_SCLK]   = !master;
				next_drive.level[PIN_RDERR] = rderr;
				next_drive.oe_n[PIN_RDERR]  = !slave;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			drive.level <= '0;
			drive.oe_n  <= PINS_OFF;
		end else begin
			drive <= next_drive;
		end
	end

	assign o_pin_out  = drive.level;
	assign o_pin_oe_n = drive.oe_n;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);

	a_parallel_pins: assert property (
		bus_en && !cfg.serial_mode |=> o_pin_oe_n[10:7] == 4'h0
			&& o_pin_out == $past(held))
		else $error("parallel pins not driven with result");
	a_chain_entry: assert property (
		slave_upd && !first_edge && !start |=> shreg[0] == $past(cfg.rdc_or_chain))
		else $error("chain level not shifted in");
	a_during_conv: assert property (
		master && bus_en && state == ST_IDLE && cfg.rdc_or_chain && i_conv_start
			&& held_valid |=> state == ST_SHIFT && shreg == $past(held))
		else $error("previous result not sent during conversion");
	a_after_conv: assert property (
		start_master && !cfg.rdc_or_chain |-> hold_take)
		else $error("read started before conversion complete");
	a_msb_load: assert property (
		start |=> shreg == $past(load_word) ##2 o_pin_out[PIN_SDATA] == $past(shreg[15], 2)
			|| !$past(bus_en))
		else $error("shifter not loaded MSB first");
	a_coding_msb: assert property (
		hold_take |=> held[15] == ($past(fifo_data[15]) ^ !$past(cfg.straight_binary)))
		else $error("MSB coding wrong");
	a_master_stable: assert property (
		master && state == ST_SHIFT && $changed(shreg) |-> $past(phase) == PHASE_SHIFT
			|| $past(start))
		else $error("master data moved near a clock edge");
	a_slave_edge: assert property (
		slave && state == ST_SHIFT && !slave_upd && !start && !abort |=> $stable(shreg))
		else $error("slave data moved off the update edge");
	a_sclk_dir: assert property (
		bus_en && cfg.serial_mode |=> o_pin_oe_n[PIN_SCLK] == !$past(master))
		else $error("clock pin direction wrong");
	a_sync_level: assert property (
		bus_en && master && state == ST_SHIFT |=> o_pin_out[PIN_SYNC]
			== !$past(cfg.sync_active_low))
		else $error("sync not active during read");
	a_bus_off: assert property (
		!bus_en |=> o_pin_oe_n == PINS_OFF)
		else $error("pins driven without chip select and read");
	a_overrun_flag: assert property (
		abort |=> state == ST_IDLE && rderr ##1 o_pin_out[PIN_RDERR] || !$past(bus_en))
		else $error("overrun not flagged");
	a_word_length: assert property (
		master_upd && bit_cnt == BITS_LAST |=> state == ST_IDLE)
		else $error("master read not sixteen bits");

	c_master_read: cover property (master_upd && bit_cnt == BITS_LAST);
	c_slave_chain: cover property (slave_upd && bit_cnt == BITS_DONE);
	c_overrun:     cover property (abort);
	c_fifo_full:   cover property (!o_conv_ready);

endmodule

// [common/adc_serial_pkg.sv]
// Constants and carrier types for the serial result port of the converter.
// Assumes a single 50 MHz system clock and a 16-bit result from the core.
package adc_serial_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int RESULT_BITS = 16;
	localparam int PIN_COUNT   = 16;
	localparam int FIFO_DEPTH  = 4;
	localparam int COUNT_BITS  = 5;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLOCK_MHZ           = 50;
	// Quarter period of the internal bit clock
	localparam int MASTER_PHASE_NS     = 40;
	localparam int MASTER_PHASE_RAW    = (MASTER_PHASE_NS * CLOCK_MHZ) / 1000;
	localparam int MASTER_PHASE_CYCLES = (MASTER_PHASE_RAW < 1) ? 1 : MASTER_PHASE_RAW;

	// ----------------------------------------------------------------
	// Shared pin positions in serial mode
	// ----------------------------------------------------------------
	localparam int PIN_CLOCK_SOURCE = 4;
	localparam int PIN_SYNC_POL     = 5;
	localparam int PIN_CLOCK_INV    = 6;
	localparam int PIN_CHAIN        = 7;
	localparam int PIN_SDATA        = 8;
	localparam int PIN_SCLK         = 9;
	localparam int PIN_SYNC         = 10;
	localparam int PIN_RDERR        = 11;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic [RESULT_BITS-1:0] RESULT_RESET = 16'h0000;
	localparam logic [PIN_COUNT-1:0]   PINS_OFF     = 16'hffff;
	localparam logic [PIN_COUNT-1:0]   PINS_ALL_ON  = 16'h0000;
	localparam logic [COUNT_BITS-1:0]  BITS_DONE    = 5'h10;
	localparam logic [COUNT_BITS-1:0]  BITS_LAST    = 5'h0f;
	localparam logic [1:0]             PHASE_SHIFT  = 2'h0;
	localparam logic [1:0]             PHASE_RISE   = 2'h1;
	localparam logic [1:0]             PHASE_FALL   = 2'h3;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic serial_mode;
		logic slave_clock;
		logic sync_active_low;
		logic clock_inverted;
		logic straight_binary;
		logic rdc_or_chain;
	} serial_cfg_t;

	typedef struct packed {
		logic [PIN_COUNT-1:0] level;
		logic [PIN_COUNT-1:0] oe_n;
	} pin_drive_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_SHIFT = 2'b10
	} port_state_t;

endpackage

// [design/result_fifo.sv]
// Small synchronous FIFO between the converter core and the serial shifter.
// Assumes both sides on one clock; read data come from the storage register.
`timescale 1ns/1ps
module result_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_srst,
	// Fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Drain side
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [CW-1:0]    fill;
	logic [CW-1:0]    next_fill;
	logic             in_ready;
	logic             push;
	logic             pop;

	assign push        = i_in_valid && in_ready;
	assign pop         = o_out_valid && i_out_ready;
	assign next_fill   = fill + CW'(push) - CW'(pop);
	// Ready kept in a flop so the fill side never sees a comparator
	assign o_in_ready  = in_ready;
	assign o_out_valid = (fill != '0);
	assign o_out_data  = store[rd_ptr];

	always_ff @(posedge i_clock) begin
		if (push) begin
			store[wr_ptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			fill     <= '0;
			in_ready <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			fill     <= next_fill;
			in_ready <= (next_fill != CW'(DEPTH));
		end
	end

endmodule

// [verif/host_model.sv]
// Host model for the serial result port: control pins, link clock, capture.
// Assumes the bench resolves each shared pin from the port's enable into i_line.
`timescale 1ns/1ps
module host_model (
	// Host control pins
	output logic             o_cs_n,
	output logic             o_rd_n,
	output logic      [15:0] o_ext,
	// Resolved shared pins
	input  wire logic [15:0] i_line
);
	logic [15:0] drive;
	logic [15:0] float_pat;
	wire  [15:0] mask = drive[4] ? 16'h02f0 : 16'h00f0;

	// Released pins wander so a stale level never passes
	assign o_ext = (drive & mask) | (float_pat & ~mask);

	initial begin
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		drive = 16'h0000;
		float_pat = 16'h5555;
		forever #20 float_pat = ~float_pat;
	end

	task automatic bus(input logic en);
		o_cs_n = ~en;
		o_rd_n = ~en;
	endtask

	task automatic set_cfg(input logic src, input logic pol, input logic inv, input logic chain);
		drive[4] = src;
		drive[5] = pol;
		drive[6] = inv;
		drive[7] = chain;
		drive[9] = inv;
	endtask

	// Takes a frame on the port's own clock, sampling data at both edges
	task automatic master_get(output logic [15:0] word, output logic [7:0] bad);
		logic act;
		int   k;
		act = ~drive[5];
		bad = 8'h00;
		// Poll off the port's clock edges so a one-cycle sync gap is seen
		#5;
		for (k = 0; k < 400 && i_line[10] === act; k++) #20;
		for (k = 0; k < 400 && i_line[10] !== act; k++) #20;
		for (k = 15; k >= 0; k--) begin
			@(i_line[9]);
			word[k] = i_line[8];
			@(i_line[9]);
			if (i_line[8] !== word[k] || i_line[10] !== act)
				bad++;
		end
	endtask

	// update edge by invert level, clock only while selected
	task automatic slave_get(input int n, output logic [31:0] word);
		int k;
		word = 32'h0;
		drive[9] = drive[6];
		o_cs_n = 1'b0;
		o_rd_n = 1'b0;
		#207;
		for (k = 0; k < n; k++) begin
			drive[9] = ~drive[6];
			#80;
			drive[9] = drive[6];
			// Late sample: port's synchroniser delay comes close to half a bit
			#70;
			word = {word[30:0], i_line[8]};
			#10;
		end
	endtask
endmodule

// [verif/adc_serial_result_port_test.sv]
// Self-checking bench for the serial result port with a host model beside it.
// Assumes a 50 MHz clock; the host link clock runs at 160 ns, phase unrelated.
`timescale 1ns/1ps
module adc_serial_result_port_test;
	import adc_serial_pkg::*;

	typedef struct packed {
		logic [15:0] result;
		logic        coding;
		logic [15:0] expect_out;
	} row_t;

	logic                   i_clock;
	logic                   i_srst;
	logic                   conv_start;
	logic                   conv_done;
	logic [RESULT_BITS-1:0] conv_result;
	logic                   conv_ready;
	logic                   sel;
	logic                   coding;
	logic                   cs_n;
	logic                   rd_n;
	logic [PIN_COUNT-1:0]   ext;
	logic [PIN_COUNT-1:0]   line;
	logic [PIN_COUNT-1:0]   pin_out;
	logic [PIN_COUNT-1:0]   pin_oe_n;
	logic                   flag_seen;
	int                     n_fail;
	int                     check_count;
	int                     i;
	int                     pushed;
	logic [15:0]            w;
	logic [7:0]             bad;
	logic [31:0]            sw;
	row_t                   rows [4];
	logic [15:0]            words [6];

	assign line = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);

	adc_serial_result_port i_adc_serial_result_port (
		.i_clock                  (i_clock),
		.i_srst                   (i_srst),
		.i_conv_start             (conv_start),
		.i_conv_done              (conv_done),
		.i_conv_result            (conv_result),
		.o_conv_ready             (conv_ready),
		.i_serial_parallel_select (sel),
		.i_output_coding_select   (coding),
		.i_cs_n                   (cs_n),
		.i_rd_n                   (rd_n),
		.i_pin_in                 (line),
		.o_pin_out                (pin_out),
		.o_pin_oe_n               (pin_oe_n)
	);

	host_model i_host_model (
		.o_cs_n (cs_n),
		.o_rd_n (rd_n),
		.o_ext  (ext),
		.i_line (line)
	);

	initial begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end

	always @(negedge i_clock)
		if (pin_oe_n[11] === 1'b0 && pin_out[11] === 1'b1)
			flag_seen = 1'b1;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(negedge i_clock);
	endtask

	task automatic push(input logic [15:0] v);
		@(negedge i_clock);
		conv_done = 1'b1;
		conv_result = v;
		@(negedge i_clock);
		conv_done = 1'b0;
	endtask

	function automatic logic [15:0] coded(input logic [15:0] v, input logic ob);
		return {v[15] ^ ~ob, v[14:0]};
	endfunction

	// Hang guard, far beyond the roughly 1600 cycles the run needs
	initial begin
		repeat (20000) @(posedge i_clock);
		n_fail++;
		close_out();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		i_srst = 1'b1;
		conv_start = 1'b0;
		conv_done = 1'b0;
		conv_result = 16'h0000;
		sel = 1'b0;
		coding = 1'b1;
		flag_seen = 1'b0;
		n_fail = 0;
		check_count = 0;
		rows = '{'{16'h1234, 1'b1, 16'h1234}, '{16'h1234, 1'b0, 16'h9234},
			'{16'h8001, 1'b0, 16'h0001}, '{16'h7ffe, 1'b1, 16'h7ffe}};
		words = '{16'h0001, 16'h8002, 16'h4004, 16'hc008, 16'h2010, 16'ha020};
		wait_clk(16);
		i_srst = 1'b0;
		wait_clk(1);
		check(32'(pin_oe_n), 32'hffff);
		check(32'(pin_out), 32'h0000);
		check(32'(conv_ready), 32'h1);
		for (i = 0; i < 4; i++) begin
			coding = rows[i].coding;
			wait_clk(4);
			push(rows[i].result);
			wait_clk(4);
			i_host_model.bus(1'b1);
			wait_clk(5);
			check(32'(pin_oe_n), 32'h0000);
			check(32'(pin_out), 32'(rows[i].expect_out));
			i_host_model.bus(1'b0);
			wait_clk(5);
			check(32'(pin_oe_n), 32'hffff);
		end
		// Master, read after convert; buffer filled while a frame shifts
		sel = 1'b1;
		i_host_model.set_cfg(1'b0, 1'b0, 1'b0, 1'b0);
		i_host_model.bus(1'b1);
		wait_clk(8);
		fork
			i_host_model.master_get(w, bad);
			begin
				push(16'ha5c3);
				wait_clk(20);
				pushed = 0;
				while (conv_ready === 1'b1 && pushed < 6) begin
					push(words[pushed]);
					pushed++;
				end
				wait_clk(2);
				check(32'(conv_ready), 32'h0);
				check(32'(pushed >= FIFO_DEPTH), 32'h1);
			end
		join
		check(32'(w), 32'ha5c3);
		check(32'(bad), 32'h0);
		for (i = 0; i < pushed; i++) begin
			i_host_model.master_get(w, bad);
			check(32'(w), 32'(words[i]));
			check(32'(bad), 32'h0);
		end
		wait_clk(4);
		check(32'(conv_ready), 32'h1);
		check(32'(pin_oe_n[9]), 32'h0);
		// Inverted sync and clock, two's complement
		i_host_model.set_cfg(1'b0, 1'b1, 1'b1, 1'b0);
		coding = 1'b0;
		wait_clk(8);
		fork
			i_host_model.master_get(w, bad);
			push(16'h5a3c);
		join
		check(32'(w), 32'hda3c);
		check(32'(bad), 32'h0);
		// Read during conversion sends the previous word
		i_host_model.set_cfg(1'b0, 1'b0, 1'b0, 1'b1);
		wait_clk(8);
		push(16'h3c5a);
		wait_clk(8);
		fork
			i_host_model.master_get(w, bad);
			begin
				conv_start = 1'b1;
				wait_clk(1);
				conv_start = 1'b0;
			end
		join
		check(32'(w), 32'(coded(16'h3c5a, coding)));
		i_host_model.bus(1'b0);
		wait_clk(8);
		// Slave mode, both clock senses, chain bit after the word
		for (i = 0; i < 2; i++) begin
			w = i ? 16'h3a5c : 16'hc3a5;
			i_host_model.set_cfg(1'b1, 1'b0, i[0], ~w[0]);
			push(w);
			wait_clk(8);
			i_host_model.slave_get(17, sw);
			check(sw, {15'h0, coded(w, coding), ~w[0]});
			check(32'(pin_oe_n[9:8]), 32'h2);
			i_host_model.bus(1'b0);
			wait_clk(8);
		end
		// Overrun in mid-read drops the word and flags it
		i_host_model.set_cfg(1'b1, 1'b0, 1'b0, 1'b0);
		push(16'h0f0f);
		wait_clk(8);
		i_host_model.slave_get(3, sw);
		flag_seen = 1'b0;
		push(16'hf0f0);
		wait_clk(8);
		check(32'(flag_seen), 32'h1);
		i_host_model.bus(1'b0);
		wait_clk(8);
		i_host_model.slave_get(16, sw);
		check(sw, {16'h0, coded(16'hf0f0, coding)});
		i_host_model.bus(1'b0);
		wait_clk(8);
		// Back to parallel: last word still held, coded
		sel = 1'b0;
		i_host_model.bus(1'b1);
		wait_clk(5);
		check(32'(pin_oe_n), 32'h0000);
		check(32'(pin_out), 32'(coded(16'hf0f0, coding)));
		// Reset in mid-read: pins let go, held word cleared
		i_srst = 1'b1;
		wait_clk(3);
		check(32'(pin_oe_n), 32'hffff);
		i_srst = 1'b0;
		wait_clk(1);
		check(32'(pin_oe_n), 32'hffff);
		check(32'(conv_ready), 32'h1);
		wait_clk(4);
		check(32'(pin_oe_n), 32'h0000);
		check(32'(pin_out), 32'h0000);
		i_host_model.bus(1'b0);
		wait_clk(8);
		close_out();
	end
endmodule
